// File: rtl/cgp_defines.vh
// Function
// - mic amp gain-in-use is a 3-bit read-only field, -6 dB at 000 to 36 dB at 111 in 6 dB steps, reset 001.
// - input mixer gain-in-use is a 4-bit read-only field, -4.5 dB at 0000 to 18.0 dB at 1111 in 1.5 dB steps.
// - left ADC digital gain-in-use is 7 bits read-only, 0x00 = -83.25 dB, 0.75 dB steps, 0x6F = 0 dB, 0x7F = 12 dB.
// - each DAC digital gain-in-use is 7 bits read-only, 0x00-0x07 mute, 0x08 = -77.25 dB, 0.75 dB steps to 12 dB.
// - each headphone gain-in-use is 6 bits read-only, 000000 = -57 dB, 1 dB steps, 111001 = 0 dB, 111111 = 6 dB.
// - mic input source is 2 bits: 00 differential, 01 positive pin, 10 negative pin, 11 reserved.
// - reference bit 4 picks slow low-noise charge (0) or fast high-noise charge (1), reset 0.
// - reference bit 3 enables the master bias for all analog circuitry, reset 1.
// - input mixer select bit 0 connects nothing (0) or the mic amp output (1), reset 0.
// - input mixer gain control is 4 bits read/write in the status encoding, reset 0x3 = 0 dB.
// - left ADC gain control is 7 bits read/write in the status encoding, reset 0x6F = 0 dB.
`ifndef CGP_DEFINES_VH
`define CGP_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CGP_OFF_MIC_NOW      8'h06
`define CGP_OFF_MIXIN_NOW    8'h08
`define CGP_OFF_ADC_NOW      8'h0A
`define CGP_OFF_DAC_L_NOW    8'h0C
`define CGP_OFF_DAC_R_NOW    8'h0D
`define CGP_OFF_HP_L_NOW     8'h0E
`define CGP_OFF_HP_R_NOW     8'h0F
`define CGP_OFF_MIC_SRC      8'h10
`define CGP_OFF_REF_BIAS     8'h32
`define CGP_OFF_MIXIN_SRC    8'h33
`define CGP_OFF_MIXIN_SET    8'h34
`define CGP_OFF_ADC_SET      8'h36
`define CGP_OFF_RAMP_BUSY    8'h3F

// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define CGP_BIT_FAST_CHARGE  4
`define CGP_BIT_BIAS_EN      3
`define CGP_MIC_SRC_RSVD     2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define CGP_RST_MIC_NOW      3'h1
`define CGP_RST_MIXIN_NOW    4'h0
`define CGP_RST_ADC_NOW      7'h00
`define CGP_RST_DAC_NOW      7'h00
`define CGP_RST_HP_NOW       6'h00
`define CGP_RST_MIC_SRC      2'h0
`define CGP_RST_FAST_CHARGE  1'h0
`define CGP_RST_BIAS_EN      1'h1
`define CGP_RST_MIXIN_SRC    1'h0
`define CGP_RST_MIXIN_SET    4'h3
`define CGP_RST_ADC_SET      7'h6F

// ----------------------------------------
// timing
// ----------------------------------------
`define CGP_CLK_NS           40
`define CGP_RAMP_STEP_NS     1000
`define CGP_RAMP_STEP_CYC    ((`CGP_RAMP_STEP_NS + `CGP_CLK_NS - 1) / `CGP_CLK_NS)
`define CGP_STEP_CNT_W       5

`endif

// File: rtl/cgp_gain_track.v
`include "cgp_defines.vh"

module cgp_gain_track #(
    parameter            W     = 7,
    parameter [W-1:0]    RST   = {W{1'b0}}
) (
    input  wire          i_clk,
    input  wire          i_reset_n,
    input  wire          i_step,
    input  wire          i_ramp_en,
    input  wire [W-1:0]  i_target,
    output reg  [W-1:0]  o_applied,
    output reg           o_busy
);

    reg [W-1:0] next_applied;

    // ----------------------------------------
    // one code per step tick while ramping
    // ----------------------------------------
    always @* begin
        next_applied = o_applied;
        if (!i_ramp_en) begin
            next_applied = i_target;
        end else if (i_step && (o_applied < i_target)) begin
            next_applied = o_applied + {{(W-1){1'b0}}, 1'b1};
        end else if (i_step && (o_applied > i_target)) begin
            next_applied = o_applied - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_applied <= RST;
            o_busy    <= 1'b0;
        end else begin
            o_applied <= next_applied;
            o_busy    <= (next_applied != i_target);
        end
    end

endmodule

// File: rtl/cgp_registers.v
// Chosen here: the plain strobed port.
`include "cgp_defines.vh"

module cgp_registers (
    input  wire        i_clk,
    input  wire        i_reset_n,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    input  wire [2:0]  i_mic_gain_set,
    input  wire [6:0]  i_dac_left_gain_set,
    input  wire [6:0]  i_dac_right_gain_set,
    input  wire [5:0]  i_hp_left_gain_set,
    input  wire [5:0]  i_hp_right_gain_set,
    input  wire        i_mic_ramp_en,
    input  wire        i_mixin_ramp_en,
    input  wire        i_adc_ramp_en,
    input  wire        i_dac_left_ramp_en,
    input  wire        i_dac_right_ramp_en,
    input  wire        i_hp_left_ramp_en,
    input  wire        i_hp_right_ramp_en,
    output reg  [1:0]  o_mic_in_sel,
    output reg         o_vmid_fast_charge,
    output reg         o_bias_en,
    output reg         o_mixin_mic_connect,
    output wire [2:0]  o_mic_gain_applied,
    output wire [3:0]  o_mixin_gain_applied,
    output wire [6:0]  o_adc_left_gain_applied,
    output wire [6:0]  o_dac_left_gain_applied,
    output wire [6:0]  o_dac_right_gain_applied,
    output wire [5:0]  o_headphone_left_gain_applied,
    output wire [5:0]  o_headphone_right_gain_applied
);

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    reg  [3:0]                  mixin_gain_set;
    reg  [6:0]                  adc_gain_set;
    reg  [`CGP_STEP_CNT_W-1:0]  step_cnt;
    reg                         step;
    reg  [7:0]                  next_rdata;

    wire                        mic_busy;
    wire                        mixin_busy;
    wire                        adc_busy;
    wire                        dac_l_busy;
    wire                        dac_r_busy;
    wire                        hp_l_busy;
    wire                        hp_r_busy;

    // counter width must cover the step time in clocks
    localparam integer               STEP_LAST_INT = `CGP_RAMP_STEP_CYC - 1;
    localparam [`CGP_STEP_CNT_W-1:0] STEP_LAST     = STEP_LAST_INT[`CGP_STEP_CNT_W-1:0];

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    wire wr_mic_src   = i_wr && hit(i_addr, `CGP_OFF_MIC_SRC);
    wire wr_ref_bias  = i_wr && hit(i_addr, `CGP_OFF_REF_BIAS);
    wire wr_mixin_src = i_wr && hit(i_addr, `CGP_OFF_MIXIN_SRC);
    wire wr_mixin_set = i_wr && hit(i_addr, `CGP_OFF_MIXIN_SET);
    wire wr_adc_set   = i_wr && hit(i_addr, `CGP_OFF_ADC_SET);

    // ----------------------------------------
    // ramp step divider
    // ----------------------------------------
    // shared tick keeps all paths ramping at one rate
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            step_cnt <= {`CGP_STEP_CNT_W{1'b0}};
            step     <= 1'b0;
        end else if (step_cnt == STEP_LAST) begin
            step_cnt <= {`CGP_STEP_CNT_W{1'b0}};
            step     <= 1'b1;
        end else begin
            step_cnt <= step_cnt + {{(`CGP_STEP_CNT_W-1){1'b0}}, 1'b1};
            step     <= 1'b0;
        end
    end

    // ----------------------------------------
    // writes
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_mic_in_sel        <= `CGP_RST_MIC_SRC;
            o_vmid_fast_charge  <= `CGP_RST_FAST_CHARGE;
            o_bias_en           <= `CGP_RST_BIAS_EN;
            o_mixin_mic_connect <= `CGP_RST_MIXIN_SRC;
            mixin_gain_set      <= `CGP_RST_MIXIN_SET;
            adc_gain_set        <= `CGP_RST_ADC_SET;
        end else begin
            // reserved source code dropped, old source kept
            if (wr_mic_src && (i_wdata[1:0] != `CGP_MIC_SRC_RSVD)) begin
                o_mic_in_sel <= i_wdata[1:0];
            end
            if (wr_ref_bias) begin
                o_vmid_fast_charge <= i_wdata[`CGP_BIT_FAST_CHARGE];
                o_bias_en          <= i_wdata[`CGP_BIT_BIAS_EN];
            end
            if (wr_mixin_src) begin
                o_mixin_mic_connect <= i_wdata[0];
            end
            if (wr_mixin_set) begin
                mixin_gain_set <= i_wdata[3:0];
            end
            if (wr_adc_set) begin
                adc_gain_set <= i_wdata[6:0];
            end
        end
    end

    // ----------------------------------------
    // applied gain trackers
    // ----------------------------------------
    cgp_gain_track #(
        .W        (3),
        .RST      (`CGP_RST_MIC_NOW)
    ) u_mic (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_mic_ramp_en),
        .i_target  (i_mic_gain_set),
        .o_applied (o_mic_gain_applied),
        .o_busy    (mic_busy)
    );

    cgp_gain_track #(
        .W        (4),
        .RST      (`CGP_RST_MIXIN_NOW)
    ) u_mixin (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_mixin_ramp_en),
        .i_target  (mixin_gain_set),
        .o_applied (o_mixin_gain_applied),
        .o_busy    (mixin_busy)
    );

    cgp_gain_track #(
        .W        (7),
        .RST      (`CGP_RST_ADC_NOW)
    ) u_adc (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_adc_ramp_en),
        .i_target  (adc_gain_set),
        .o_applied (o_adc_left_gain_applied),
        .o_busy    (adc_busy)
    );

    // codes below 0x08 ramp through mute like any other code
    cgp_gain_track #(
        .W        (7),
        .RST      (`CGP_RST_DAC_NOW)
    ) u_dac_l (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_dac_left_ramp_en),
        .i_target  (i_dac_left_gain_set),
        .o_applied (o_dac_left_gain_applied),
        .o_busy    (dac_l_busy)
    );

    cgp_gain_track #(
        .W        (7),
        .RST      (`CGP_RST_DAC_NOW)
    ) u_dac_r (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_dac_right_ramp_en),
        .i_target  (i_dac_right_gain_set),
        .o_applied (o_dac_right_gain_applied),
        .o_busy    (dac_r_busy)
    );

    cgp_gain_track #(
        .W        (6),
        .RST      (`CGP_RST_HP_NOW)
    ) u_hp_l (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_hp_left_ramp_en),
        .i_target  (i_hp_left_gain_set),
        .o_applied (o_headphone_left_gain_applied),
        .o_busy    (hp_l_busy)
    );

    cgp_gain_track #(
        .W        (6),
        .RST      (`CGP_RST_HP_NOW)
    ) u_hp_r (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_ramp_en (i_hp_right_ramp_en),
        .i_target  (i_hp_right_gain_set),
        .o_applied (o_headphone_right_gain_applied),
        .o_busy    (hp_r_busy)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // reserved bits and unmapped offsets read as zero
    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `CGP_OFF_MIC_NOW: begin
                next_rdata = {5'h00, o_mic_gain_applied};
            end
            `CGP_OFF_MIXIN_NOW: begin
                next_rdata = {4'h0, o_mixin_gain_applied};
            end
            `CGP_OFF_ADC_NOW: begin
                next_rdata = {1'h0, o_adc_left_gain_applied};
            end
            `CGP_OFF_DAC_L_NOW: begin
                next_rdata = {1'h0, o_dac_left_gain_applied};
            end
            `CGP_OFF_DAC_R_NOW: begin
                next_rdata = {1'h0, o_dac_right_gain_applied};
            end
            `CGP_OFF_HP_L_NOW: begin
                next_rdata = {2'h0, o_headphone_left_gain_applied};
            end
            `CGP_OFF_HP_R_NOW: begin
                next_rdata = {2'h0, o_headphone_right_gain_applied};
            end
            `CGP_OFF_MIC_SRC: begin
                next_rdata = {6'h00, o_mic_in_sel};
            end
            `CGP_OFF_REF_BIAS: begin
                next_rdata = {3'h0, o_vmid_fast_charge, o_bias_en, 3'h0};
            end
            `CGP_OFF_MIXIN_SRC: begin
                next_rdata = {7'h00, o_mixin_mic_connect};
            end
            `CGP_OFF_MIXIN_SET: begin
                next_rdata = {4'h0, mixin_gain_set};
            end
            `CGP_OFF_ADC_SET: begin
                next_rdata = {1'h0, adc_gain_set};
            end
            `CGP_OFF_RAMP_BUSY: begin
                next_rdata = {1'h0, hp_r_busy, hp_l_busy, dac_r_busy,
                              dac_l_busy, adc_busy, mixin_busy, mic_busy};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// File: verification/cgp_registers_props.sv
// ----------------------------------------
// register bank properties
// ----------------------------------------
module cgp_registers_props (
    input logic       i_clk,
    input logic       i_reset_n,
    input logic [7:0] i_addr,
    input logic [7:0] i_wdata,
    input logic       i_wr,
    input logic       i_rd,
    input logic [7:0] o_rdata,
    input logic [2:0] i_mic_gain_set,
    input logic [6:0] i_dac_right_gain_set,
    input logic [5:0] i_hp_left_gain_set,
    input logic       i_mic_ramp_en,
    input logic       i_dac_right_ramp_en,
    input logic       i_hp_left_ramp_en,
    input logic       i_adc_ramp_en,
    input logic [1:0] o_mic_in_sel,
    input logic       o_vmid_fast_charge,
    input logic       o_bias_en,
    input logic       o_mixin_mic_connect,
    input logic [2:0] o_mic_gain_applied,
    input logic [6:0] o_adc_left_gain_applied,
    input logic [6:0] o_dac_right_gain_applied,
    input logic [5:0] o_headphone_left_gain_applied
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_mic_read;
        i_rd && i_addr == 8'h10 |=> o_rdata == {6'h00, $past(o_mic_in_sel)};
    endproperty
    property p_mic_rsvd;
        i_wr && i_addr == 8'h10 && i_wdata[1:0] == 2'h3 |=> $stable(o_mic_in_sel);
    endproperty
    property p_mic_write;
        i_wr && i_addr == 8'h10 && i_wdata[1:0] != 2'h3 |=> o_mic_in_sel == $past(i_wdata[1:0]);
    endproperty
    property p_charge;
        i_wr && i_addr == 8'h32 |=> o_vmid_fast_charge == $past(i_wdata[4]);
    endproperty
    property p_bias;
        i_wr && i_addr == 8'h32 |=> o_bias_en == $past(i_wdata[3]);
    endproperty
    property p_ref_hold;
        !(i_wr && i_addr == 8'h32) |=> $stable(o_bias_en) && $stable(o_vmid_fast_charge);
    endproperty
    property p_mix_sel;
        i_wr && i_addr == 8'h33 |=> o_mixin_mic_connect == $past(i_wdata[0]);
    endproperty
    property p_mic_follow;
        !i_mic_ramp_en |=> o_mic_gain_applied == $past(i_mic_gain_set);
    endproperty
    property p_hp_follow;
        !i_hp_left_ramp_en |=> o_headphone_left_gain_applied == $past(i_hp_left_gain_set);
    endproperty
    property p_dac_follow;
        !i_dac_right_ramp_en |=> o_dac_right_gain_applied == $past(i_dac_right_gain_set);
    endproperty
    // ramping must never skip a code
    property p_adc_ramp;
        i_adc_ramp_en ##1 i_adc_ramp_en |-> o_adc_left_gain_applied == $past(o_adc_left_gain_applied) ||
            o_adc_left_gain_applied == $past(o_adc_left_gain_applied) + 7'h01 ||
            o_adc_left_gain_applied == $past(o_adc_left_gain_applied) - 7'h01;
    endproperty

    a_mic_read: assert property (p_mic_read) else $error("mic source readback wrong");
    a_mic_rsvd: assert property (p_mic_rsvd) else $error("reserved mic code taken");
    a_mic_write: assert property (p_mic_write) else $error("mic source not written");
    a_charge: assert property (p_charge) else $error("fast charge bit wrong");
    a_bias: assert property (p_bias) else $error("bias enable bit wrong");
    a_ref_hold: assert property (p_ref_hold) else $error("reference bits moved");
    a_mix_sel: assert property (p_mix_sel) else $error("mixer select wrong");
    a_mic_follow: assert property (p_mic_follow) else $error("mic gain not applied");
    a_hp_follow: assert property (p_hp_follow) else $error("headphone gain not applied");
    a_dac_follow: assert property (p_dac_follow) else $error("dac gain not applied");
    a_adc_ramp: assert property (p_adc_ramp) else $error("adc gain jumped");

    c_rsvd: cover property (i_wr && i_addr == 8'h10 && i_wdata[1:0] == 2'h3);
    c_ramp: cover property (i_adc_ramp_en ##1 !$stable(o_adc_left_gain_applied));
    c_rd_pair: cover property (i_rd ##1 i_rd);
endmodule

bind cgp_registers cgp_registers_props cgp_registers_props_inst (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_mic_gain_set, .i_dac_right_gain_set, .i_hp_left_gain_set, .i_mic_ramp_en,
    .i_dac_right_ramp_en, .i_hp_left_ramp_en, .i_adc_ramp_en, .o_mic_in_sel, .o_vmid_fast_charge, .o_bias_en,
    .o_mixin_mic_connect, .o_mic_gain_applied, .o_adc_left_gain_applied, .o_dac_right_gain_applied,
    .o_headphone_left_gain_applied);

// File: verification/cgp_tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk = 1'b0;
    logic       i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [2:0] i_mic_gain_set = 3'h5;
    logic [6:0] i_dac_left_gain_set = 7'h07;
    logic [6:0] i_dac_right_gain_set = 7'h08;
    logic [5:0] i_hp_left_gain_set = 6'h39;
    logic [5:0] i_hp_right_gain_set = 6'h3F;
    logic [6:0] ramp = 7'h00;
    wire  [7:0] o_rdata;
    wire  [1:0] o_mic_in_sel;
    wire        o_vmid_fast_charge, o_bias_en, o_mixin_mic_connect;
    wire  [2:0] o_mic_gain_applied;
    wire  [3:0] o_mixin_gain_applied;
    wire  [6:0] o_adc_left_gain_applied, o_dac_left_gain_applied, o_dac_right_gain_applied;
    wire  [5:0] o_headphone_left_gain_applied, o_headphone_right_gain_applied;
    int         errors = 0;
    int         comparisons = 0;
    // {write, offset, data, expected read}; status rows rely on ramping being off
    logic [24:0] rows [0:21] = '{25'h036006F, 25'h0340003, 25'h0320008, 25'h0100000, 25'h0330000,
        25'h00A006F, 25'h0080003, 25'h0060005, 25'h00C0007, 25'h00D0008, 25'h00E0039, 25'h00F003F,
        25'h1100101, 25'h1100202, 25'h132FF18, 25'h1320000, 25'h133FF01, 25'h134FF0F, 25'h1368000,
        25'h10A5500, 25'h106FF05, 25'h107FF00};
    logic [6:0] codes [0:3] = '{7'h00, 7'h07, 7'h08, 7'h7F};

    cgp_registers cgp_registers_inst (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_mic_gain_set, .i_dac_left_gain_set, .i_dac_right_gain_set, .i_hp_left_gain_set, .i_hp_right_gain_set,
        .i_mic_ramp_en(ramp[0]), .i_mixin_ramp_en(ramp[1]), .i_adc_ramp_en(ramp[2]),
        .i_dac_left_ramp_en(ramp[3]), .i_dac_right_ramp_en(ramp[4]), .i_hp_left_ramp_en(ramp[5]),
        .i_hp_right_ramp_en(ramp[6]), .o_mic_in_sel, .o_vmid_fast_charge, .o_bias_en, .o_mixin_mic_connect,
        .o_mic_gain_applied, .o_mixin_gain_applied, .o_adc_left_gain_applied, .o_dac_left_gain_applied,
        .o_dac_right_gain_applied, .o_headphone_left_gain_applied, .o_headphone_right_gain_applied);

    always #20 i_clk = ~i_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, exp);
    endtask

    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // watchdog, far beyond the few hundred cycles used
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge i_clk);
        errors++;
        stop_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        check({5'h00, o_mic_gain_applied}, 8'h01);
        check({3'h0, o_bias_en, o_vmid_fast_charge, o_mixin_mic_connect, o_mic_in_sel}, 8'h10);
        check({1'b0, o_adc_left_gain_applied}, 8'h00);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        foreach (rows[k]) begin
            if (rows[k][24]) begin
                wr_reg(rows[k][23:16], rows[k][15:8]);
            end
            rd_reg(rows[k][23:16], rows[k][7:0]);
        end
        // reserved source code leaves the old one in place
        wr_reg(8'h10, 8'h01);
        wr_reg(8'h10, 8'h03);
        rd_reg(8'h10, 8'h01);
        check({6'h00, o_mic_in_sel}, 8'h01);
        // back-to-back reads, data stands one cycle
        wr_reg(8'h36, 8'h20);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= 8'h34;
        @(posedge i_clk);
        i_addr <= 8'h36;
        @(negedge i_clk);
        check(o_rdata, 8'h0F);
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, 8'h20);
        @(negedge i_clk);
        check(o_rdata, 8'h00);
        // boundary codes on the port-fed targets
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            i_dac_right_gain_set <= codes[k];
            i_dac_left_gain_set <= codes[k];
            i_hp_right_gain_set <= codes[k][5:0];
            i_hp_left_gain_set <= codes[k][5:0];
            i_mic_gain_set <= codes[k][2:0];
            repeat (2) @(negedge i_clk);
            check({1'b0, o_dac_right_gain_applied}, {1'b0, codes[k]});
            check({1'b0, o_dac_left_gain_applied}, {1'b0, codes[k]});
            check({2'h0, o_headphone_right_gain_applied}, {2'h0, codes[k][5:0]});
            check({2'h0, o_headphone_left_gain_applied}, {2'h0, codes[k][5:0]});
            check({5'h00, o_mic_gain_applied}, {5'h00, codes[k][2:0]});
        end
        // ramped change lags the setting for two step ticks
        @(posedge i_clk);
        ramp <= 7'h04;
        wr_reg(8'h36, 8'h22);
        rd_reg(8'h3F, 8'h04);
        repeat (60) @(posedge i_clk);
        rd_reg(8'h0A, 8'h22);
        rd_reg(8'h3F, 8'h00);
        // second reset mid-run restores defaults
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_reg(8'h10, 8'h00);
        rd_reg(8'h36, 8'h6F);
        rd_reg(8'h32, 8'h08);
        stop_test();
    end
endmodule
